// ### hdl/ascd_pkg.sv
package ascd_pkg;

    localparam logic [6:0] OPB_RESUME = 7'h00;
    localparam logic [6:0] OPB_STANDBY = 7'h01;
    localparam logic [6:0] OPB_RESYNC = 7'h02;
    localparam logic [6:0] OPB_SOFT_RESET = 7'h03;
    localparam logic [7:0] OP_CONT_READ = 8'h10;
    localparam logic [7:0] OP_STOP_CONT = 8'h11;
    localparam logic [7:0] OP_ONE_SHOT = 8'h12;
    localparam logic [7:0] OP_OFFSET_CAL = 8'h60;
    localparam logic [7:0] OP_GAIN_CAL = 8'h61;
    localparam logic [2:0] OPP_REG_READ = 3'h1;
    localparam logic [2:0] OPP_REG_WRITE = 3'h2;

    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [4:0] CAL_LAST = 5'h0f;
    localparam int CAL_SHIFT = 4;

    localparam logic [4:0] ADDR_ID = 5'h00;
    localparam logic [4:0] ADDR_LAST = 5'h0a;
    localparam logic [4:0] ADDR_OFFSET_LO = 5'h05;
    localparam logic [4:0] ADDR_GAIN_LO = 5'h08;
    // arbitrary identification nibble
    localparam logic [3:0] ID_NIBBLE = 4'h5;

    localparam logic [7:0] RST_CONFIG0 = 8'h52;
    localparam logic [7:0] RST_RESERVED = 8'h08;
    localparam logic [7:0] RST_HPF0 = 8'h32;
    localparam logic [7:0] RST_HPF1 = 8'h03;
    localparam logic [7:0] RST_GAIN_HI = 8'h40;

    typedef enum logic [2:0] {ST_OPCODE, ST_RD_COUNT, ST_WR_COUNT, ST_RD_DATA, ST_WR_DATA}
        ascd_state_e;
    typedef enum logic [1:0] {CAL_IDLE, CAL_OFFSET, CAL_GAIN} ascd_cal_e;

    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } ascd_wr_s;

    typedef struct packed {
        logic ofs_en;
        logic gain_en;
        logic [23:0] val;
    } ascd_cal_s;

    function automatic logic [7:0] ascd_reg_default(input logic [4:0] addr);
        case (addr)
            ADDR_ID: ascd_reg_default = {ID_NIBBLE, 4'h0};
            5'h01: ascd_reg_default = RST_CONFIG0;
            5'h02: ascd_reg_default = RST_RESERVED;
            5'h03: ascd_reg_default = RST_HPF0;
            5'h04: ascd_reg_default = RST_HPF1;
            ADDR_LAST: ascd_reg_default = RST_GAIN_HI;
            default: ascd_reg_default = 8'h00;
        endcase
    endfunction : ascd_reg_default

endpackage : ascd_pkg

// ### hdl/ascd_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module ascd_regfile
    import ascd_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic defaults_in,
    input wire ascd_wr_s wr_in,
    input wire ascd_cal_s cal_in,
    input wire logic [4:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    output logic [23:0] offset_corr_out,
    output logic [23:0] gain_corr_out
);
    typedef struct packed {
        logic [31:0][7:0] mem;
        logic [7:0] rd_data;
    } ascd_rf_s;

    ascd_rf_s r;
    ascd_rf_s next_r;

    always_comb
    begin
        next_r = r;
        next_r.rd_data = r.mem[rd_addr_in];
        if (defaults_in)
        begin
            for (int i = 0; i < 32; i++)
            begin
                next_r.mem[i] = ascd_reg_default(5'(i));
            end
        end
        else
        begin
            // id register is read-only, unmapped space stays zero
            if (wr_in.en && wr_in.addr != ADDR_ID && wr_in.addr <= ADDR_LAST)
            begin
                next_r.mem[wr_in.addr] = wr_in.data;
            end
            if (cal_in.ofs_en)
            begin
                {next_r.mem[ADDR_OFFSET_LO + 5'h2], next_r.mem[ADDR_OFFSET_LO + 5'h1],
                    next_r.mem[ADDR_OFFSET_LO]} = cal_in.val;
            end
            if (cal_in.gain_en)
            begin
                {next_r.mem[ADDR_GAIN_LO + 5'h2], next_r.mem[ADDR_GAIN_LO + 5'h1],
                    next_r.mem[ADDR_GAIN_LO]} = cal_in.val;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            r.rd_data <= 8'h00;
            r.mem <= '0;
            r.mem[ADDR_ID] <= {ID_NIBBLE, 4'h0};
            r.mem[1] <= RST_CONFIG0;
            r.mem[2] <= RST_RESERVED;
            r.mem[3] <= RST_HPF0;
            r.mem[4] <= RST_HPF1;
            r.mem[ADDR_LAST] <= RST_GAIN_HI;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rd_data_out = r.rd_data;
    assign offset_corr_out = {r.mem[ADDR_OFFSET_LO + 5'h2], r.mem[ADDR_OFFSET_LO + 5'h1],
        r.mem[ADDR_OFFSET_LO]};
    assign gain_corr_out = {r.mem[ADDR_GAIN_LO + 5'h2], r.mem[ADDR_GAIN_LO + 5'h1],
        r.mem[ADDR_GAIN_LO]};
endmodule : ascd_regfile
`default_nettype wire

// ### hdl/ascd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ascd_decoder
    import ascd_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SCLK_IN,
    input wire logic DIN_IN,
    input wire logic CONFIG_SELECT_PIN_IN,
    input wire logic CONV_VALID_IN,
    input wire logic [31:0] CONV_DATA_IN,
    input wire logic GAIN_CORR_VALID_IN,
    input wire logic [23:0] GAIN_CORR_IN,
    output logic DOUT_OUT,
    output logic RESULT_READY_N_OUT,
    output logic STANDBY_OUT,
    output logic RESTART_OUT,
    output logic GAIN_CAL_REQ_OUT,
    output logic CONT_MODE_OUT,
    output logic [23:0] OFFSET_CORR_OUT,
    output logic [23:0] GAIN_CORR_OUT
);
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] din_s;
        logic [2:0] cfg_s;
        logic sclk_f;
        logic pin_mode;
        logic [2:0] bit_cnt;
        logic [7:0] in_sh;
        ascd_state_e state;
        logic [4:0] addr;
        logic [4:0] count;
        logic cont_mode;
        logic standby;
        logic restart;
        logic soft_reset;
        logic ready_n;
        logic dout;
        logic [31:0] out_sh;
        logic pend;
        logic [31:0] pend_word;
        logic [1:0] ld_dly;
        logic [31:0] latest;
        ascd_cal_e cal;
        logic [4:0] cal_cnt;
        logic [27:0] cal_sum;
        logic gain_req;
        ascd_wr_s wr;
        ascd_cal_s cal_ld;
    } ascd_top_s;

    ascd_top_s r;
    ascd_top_s next_r;
    logic [7:0] rd_data;
    logic sclk_rise;
    logic sclk_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [27:0] sum_new;

    ascd_regfile u_regfile (
        .clk_in(SYS_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .defaults_in(r.soft_reset),
        .wr_in(r.wr),
        .cal_in(r.cal_ld),
        .rd_addr_in(r.addr),
        .rd_data_out(rd_data),
        .offset_corr_out(OFFSET_CORR_OUT),
        .gain_corr_out(GAIN_CORR_OUT)
    );

    // filtered edges: second and third sync stages must agree
    assign sclk_rise = r.sclk_s[1] && r.sclk_s[2] && !r.sclk_f;
    assign sclk_fall = !r.sclk_s[1] && !r.sclk_s[2] && r.sclk_f;
    assign rx_byte = {r.in_sh[6:0], r.din_s[2]};
    assign byte_done = sclk_rise && r.bit_cnt == BYTE_LAST;
    assign sum_new = r.cal_sum + {{4{CONV_DATA_IN[31]}}, CONV_DATA_IN[31:8]};

    always_comb
    begin
        next_r = r;
        next_r.sclk_s = {r.sclk_s[1:0], SCLK_IN};
        next_r.din_s = {r.din_s[1:0], DIN_IN};
        next_r.cfg_s = {r.cfg_s[1:0], CONFIG_SELECT_PIN_IN};
        if (r.sclk_s[1] == r.sclk_s[2])
        begin
            next_r.sclk_f = r.sclk_s[2];
        end
        if (r.cfg_s[1] == r.cfg_s[2])
        begin
            next_r.pin_mode = r.cfg_s[2];
        end
        next_r.restart = 1'b0;
        next_r.soft_reset = 1'b0;
        next_r.wr.en = 1'b0;
        next_r.cal_ld.ofs_en = 1'b0;
        next_r.cal_ld.gain_en = 1'b0;
        next_r.ld_dly = {r.ld_dly[0], 1'b0};
        if (sclk_rise)
        begin
            next_r.in_sh = rx_byte;
            next_r.bit_cnt = r.bit_cnt + 3'h1;
        end
        // serial output: one bit per falling edge
        if (sclk_fall)
        begin
            next_r.ready_n = 1'b1;
            if (r.pend)
            begin
                next_r.dout = r.pend_word[31];
                next_r.out_sh = {r.pend_word[30:0], 1'b0};
                next_r.pend = 1'b0;
            end
            else
            begin
                next_r.dout = r.out_sh[31];
                next_r.out_sh = {r.out_sh[30:0], 1'b0};
            end
        end
        // register byte fetched two cycles after address moves
        if (r.ld_dly[1])
        begin
            next_r.pend_word = {rd_data, 24'h00_0000};
            next_r.pend = 1'b1;
        end
        if (CONV_VALID_IN && !r.standby)
        begin
            next_r.latest = CONV_DATA_IN;
            if (r.cont_mode && r.state == ST_OPCODE)
            begin
                next_r.ready_n = 1'b0;
                next_r.dout = CONV_DATA_IN[31];
                next_r.out_sh = {CONV_DATA_IN[30:0], 1'b0};
                next_r.pend = 1'b0;
            end
            if (r.cal == CAL_OFFSET)
            begin
                next_r.cal_sum = sum_new;
                next_r.cal_cnt = r.cal_cnt + 5'h01;
                if (r.cal_cnt == CAL_LAST)
                begin
                    next_r.cal_ld.ofs_en = 1'b1;
                    next_r.cal_ld.val = sum_new[CAL_SHIFT +: 24];
                    next_r.cal = CAL_IDLE;
                end
            end
        end
        if (r.cal == CAL_GAIN && GAIN_CORR_VALID_IN)
        begin
            next_r.cal_ld.gain_en = 1'b1;
            next_r.cal_ld.val = GAIN_CORR_IN;
            next_r.gain_req = 1'b0;
            next_r.cal = CAL_IDLE;
        end
        if (byte_done && !r.pin_mode)
        begin
            case (r.state)
                ST_OPCODE:
                begin
                    if (rx_byte[7:1] == OPB_RESUME)
                    begin
                        if (r.standby)
                        begin
                            next_r.standby = 1'b0;
                            next_r.restart = 1'b1;
                        end
                    end
                    else if (rx_byte[7:1] == OPB_STANDBY)
                    begin
                        next_r.standby = 1'b1;
                    end
                    else if (rx_byte[7:1] == OPB_RESYNC)
                    begin
                        next_r.restart = 1'b1;
                    end
                    else if (rx_byte[7:1] == OPB_SOFT_RESET)
                    begin
                        next_r.soft_reset = 1'b1;
                        next_r.cont_mode = 1'b1;
                        next_r.standby = 1'b0;
                        next_r.restart = 1'b1;
                        next_r.ready_n = 1'b1;
                        next_r.cal = CAL_IDLE;
                        next_r.gain_req = 1'b0;
                    end
                    else if (rx_byte == OP_CONT_READ)
                    begin
                        next_r.cont_mode = 1'b1;
                    end
                    else if (rx_byte == OP_STOP_CONT)
                    begin
                        next_r.cont_mode = 1'b0;
                        next_r.ready_n = 1'b1;
                    end
                    else if (rx_byte == OP_ONE_SHOT)
                    begin
                        if (!r.cont_mode)
                        begin
                            next_r.pend_word = r.latest;
                            next_r.pend = 1'b1;
                        end
                    end
                    else if (rx_byte[7:5] == OPP_REG_READ)
                    begin
                        if (!r.cont_mode)
                        begin
                            next_r.addr = rx_byte[4:0];
                            next_r.state = ST_RD_COUNT;
                        end
                    end
                    else if (rx_byte[7:5] == OPP_REG_WRITE)
                    begin
                        next_r.addr = rx_byte[4:0];
                        next_r.state = ST_WR_COUNT;
                    end
                    else if (rx_byte == OP_OFFSET_CAL)
                    begin
                        next_r.cal = CAL_OFFSET;
                        next_r.cal_cnt = 5'h00;
                        next_r.cal_sum = 28'h000_0000;
                        next_r.gain_req = 1'b0;
                    end
                    else if (rx_byte == OP_GAIN_CAL)
                    begin
                        next_r.cal = CAL_GAIN;
                        next_r.gain_req = 1'b1;
                    end
                    // anything else falls through untouched
                end
                ST_RD_COUNT:
                begin
                    next_r.count = rx_byte[4:0];
                    next_r.state = ST_RD_DATA;
                    next_r.ld_dly = 2'b01;
                end
                ST_RD_DATA:
                begin
                    if (r.count == 5'h00)
                    begin
                        next_r.state = ST_OPCODE;
                    end
                    else
                    begin
                        next_r.count = r.count - 5'h01;
                        next_r.addr = r.addr + 5'h01;
                        next_r.ld_dly = 2'b01;
                    end
                end
                ST_WR_COUNT:
                begin
                    next_r.count = rx_byte[4:0];
                    next_r.state = ST_WR_DATA;
                end
                ST_WR_DATA:
                begin
                    next_r.wr.en = 1'b1;
                    next_r.wr.addr = r.addr;
                    next_r.wr.data = rx_byte;
                    next_r.addr = r.addr + 5'h01;
                    if (r.count == 5'h00)
                    begin
                        next_r.state = ST_OPCODE;
                    end
                    else
                    begin
                        next_r.count = r.count - 5'h01;
                    end
                end
                default:
                begin
                    next_r.state = ST_OPCODE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            r <= '0;
            r.state <= ST_OPCODE;
            r.cal <= CAL_IDLE;
            r.cont_mode <= 1'b1;
            r.ready_n <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign DOUT_OUT = r.dout;
    assign RESULT_READY_N_OUT = r.ready_n;
    assign STANDBY_OUT = r.standby;
    assign RESTART_OUT = r.restart;
    assign GAIN_CAL_REQ_OUT = r.gain_req;
    assign CONT_MODE_OUT = r.cont_mode;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    logic op_ok;
    assign op_ok = byte_done && !r.pin_mode && r.state == ST_OPCODE;

    AST_PIN_MODE_IGNORES: assert property (
        byte_done && r.pin_mode && !CONV_VALID_IN |=> $stable(r.cont_mode) && !r.restart
            && $stable(r.state))
        else $error("command acted outside register mode");
    AST_REG_MODE_STATE: assert property (
        r.state != ST_OPCODE |-> !r.pin_mode || $past(r.state) != ST_OPCODE)
        else $error("command sequence begun in pin mode");
    AST_RESUME: assert property (
        op_ok && rx_byte[7:1] == OPB_RESUME && r.standby |=> !r.standby && r.restart)
        else $error("resume did not leave standby");
    AST_RESUME_IGNORED: assert property (
        op_ok && rx_byte[7:1] == OPB_RESUME && !r.standby |=> !r.restart && !r.standby)
        else $error("resume outside standby had an effect");
    AST_STANDBY: assert property (
        op_ok && rx_byte[7:1] == OPB_STANDBY |=> r.standby ##1 STANDBY_OUT)
        else $error("standby not entered");
    AST_RESYNC: assert property (
        op_ok && rx_byte[7:1] == OPB_RESYNC |=> r.restart ##1 !r.restart)
        else $error("resync pulse wrong");
    AST_SOFT_RESET: assert property (
        op_ok && rx_byte[7:1] == OPB_SOFT_RESET |=> r.soft_reset && r.cont_mode && r.restart)
        else $error("soft reset incomplete");
    AST_READY_LOW: assert property (
        CONV_VALID_IN && !r.standby && r.cont_mode && r.state == ST_OPCODE |=> !r.ready_n)
        else $error("result ready not asserted");
    AST_CONT_MSB: assert property (
        CONV_VALID_IN && !r.standby && r.cont_mode && r.state == ST_OPCODE
            |=> r.dout == $past(CONV_DATA_IN[31]))
        else $error("continuous data msb not driven");
    AST_STOP_CONT: assert property (
        op_ok && rx_byte == OP_STOP_CONT |=> !r.cont_mode && r.ready_n)
        else $error("continuous mode not stopped");
    AST_REG_READ_FETCH: assert property (
        byte_done && !r.pin_mode && r.state == ST_RD_COUNT |=> ##2 r.pend)
        else $error("register byte not staged for output");
    AST_REG_WRITE_STORE: assert property (
        byte_done && !r.pin_mode && r.state == ST_WR_DATA |=> r.wr.en
            && r.wr.data == $past(rx_byte))
        else $error("write data not stored");
    AST_UNKNOWN_OP: assert property (
        op_ok && rx_byte == 8'h13 |=> r.state == ST_OPCODE && $stable(r.cont_mode)
            && $stable(r.standby))
        else $error("undefined opcode changed state");

    COV_REG_READ: cover property (r.state == ST_RD_DATA && byte_done && r.count == 5'h00);
    COV_REG_WRITE: cover property (r.wr.en);
    COV_OFFSET_CAL: cover property (r.cal_ld.ofs_en);
    COV_WAKE: cover property (op_ok && rx_byte[7:1] == OPB_RESUME && r.standby);
endmodule : ascd_decoder
`default_nettype wire

// ### test/ascd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ascd_host_model
    import ascd_pkg::*;
(
    input wire logic clk_in,
    input wire logic dout_in,
    output logic sclk_out,
    output logic din_out
);
    initial
    begin
        sclk_out = 1'b0;
        din_out = 1'b0;
    end

    // one byte msb first, dout taken just before each rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            din_out <= tx[i];
            repeat (8) @(posedge clk_in);
            rx[i] = dout_in;
            sclk_out <= 1'b1;
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        // released data line must not look like held data
        din_out <= ~tx[0];
        repeat (28) @(posedge clk_in);
    endtask : xfer
endmodule : ascd_host_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ascd_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfg = 1'b0;
    logic conv_valid = 1'b0;
    logic [31:0] conv_data = '0;
    logic gain_valid = 1'b0;
    logic [23:0] gain_data = '0;
    logic sclk, din, dout, rdy_n, stby, restart, gain_req, cont;
    logic [23:0] ofs, gain;
    logic [31:0] seed = 32'h0000_9dd3;
    int mismatches = 0;
    int tests_run = 0;
    int restarts = 0;
    int cycles = 0;
    logic [31:0] v;
    logic [7:0] b;
    logic [23:0] w;
    logic [31:0] cal[16];

    always #2 clk = ~clk;

    ascd_host_model i_ascd_host_model (.clk_in(clk), .dout_in(dout), .sclk_out(sclk),
        .din_out(din));

    ascd_decoder i_ascd_decoder (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .SCLK_IN(sclk),
        .DIN_IN(din), .CONFIG_SELECT_PIN_IN(cfg), .CONV_VALID_IN(conv_valid),
        .CONV_DATA_IN(conv_data), .GAIN_CORR_VALID_IN(gain_valid), .GAIN_CORR_IN(gain_data),
        .DOUT_OUT(dout), .RESULT_READY_N_OUT(rdy_n), .STANDBY_OUT(stby),
        .RESTART_OUT(restart), .GAIN_CAL_REQ_OUT(gain_req), .CONT_MODE_OUT(cont),
        .OFFSET_CORR_OUT(ofs), .GAIN_CORR_OUT(gain));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // signed mean of the upper 24 bits of sixteen results
    function automatic logic [23:0] avg16(input logic [31:0] d[16]);
        logic [27:0] s;
        s = '0;
        foreach (d[i])
            s = s + {{4{d[i][31]}}, d[i][31:8]};
        return s[27:4];
    endfunction : avg16

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic send(input logic [7:0] tx);
        i_ascd_host_model.xfer(tx, b);
    endtask : send

    // clock n bytes of filler in and gather what comes out
    task automatic rdw(input int n, output logic [31:0] r);
        r = '0;
        repeat (n)
        begin
            i_ascd_host_model.xfer(8'h00, b);
            r = {r[23:0], b};
        end
    endtask : rdw

    task automatic conv(input logic [31:0] d);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(posedge clk);
        conv_valid <= 1'b0;
        @(posedge clk);
    endtask : conv

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (restart === 1'b1)
            restarts <= restarts + 1;
        if (cycles == 40000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        chk("cont", 1, cont);
        chk("gain", 32'h0040_0000, gain);
        chk("ready", 1, rdy_n);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        w = 24'(rnd());
        conv(w);
        chk("ready", 0, rdy_n);
        rdw(4, v);
        chk("stream", w, v);
        chk("standby", 0, stby);
        chk("restarts", 0, restarts);
        send(8'h11);
        chk("cont", 0, cont);
        conv(rnd());
        chk("ready", 1, rdy_n);
        w = 24'(rnd());
        conv(w);
        send(8'h12);
        rdw(4, v);
        chk("oneshot", w, v);
        w = 24'(rnd());
        send(8'h45);
        send(8'h02);
        for (int i = 0; i < 3; i++)
            send(w[8*i +: 8]);
        chk("offset", w, ofs);
        send(8'h24);
        send(8'h03);
        rdw(4, v);
        chk("regread", {RST_HPF1, w[7:0], w[15:8], w[23:16]}, v);
        send(8'h3f);
        send(8'h01);
        rdw(2, v);
        chk("wrapread", {ID_NIBBLE, 4'h0}, v);
        for (int x = 0; x < 2; x++)
        begin
            send(8'h02 | x[7:0]);
            chk("standby", 1, stby);
            chk("offset", w, ofs);
            send(8'h00 | x[7:0]);
            chk("standby", 0, stby);
            send(8'h04 | x[7:0]);
            chk("restarts", 2 * x + 2, restarts);
        end
        send(8'h13);
        send(8'h7f);
        chk("cont", 0, cont);
        chk("offset", w, ofs);
        cfg <= 1'b1;
        repeat (8) @(posedge clk);
        send(8'h02);
        chk("standby", 0, stby);
        cfg <= 1'b0;
        repeat (8) @(posedge clk);
        gain_data <= 24'(rnd());
        send(8'h61);
        chk("gainreq", 1, gain_req);
        gain_valid <= 1'b1;
        @(posedge clk);
        gain_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("gain", gain_data, gain);
        chk("gainreq", 0, gain_req);
        send(8'h60);
        for (int i = 0; i < 16; i++)
        begin
            cal[i] = (i == 3) ? 32'h8000_0000 : rnd();
            conv(cal[i]);
        end
        repeat (3) @(posedge clk);
        chk("offcal", avg16(cal), ofs);
        send(8'h07);
        chk("cont", 1, cont);
        chk("offset", 0, ofs);
        chk("gain", 32'h0040_0000, gain);
        chk("restarts", 5, restarts);
        send(8'h11);
        send(8'h10);
        chk("cont", 1, cont);
        // mid-run pin reset out of standby with continuous mode off
        send(8'h11);
        send(8'h02);
        chk("standby", 1, stby);
        chk("cont", 0, cont);
        arst_n <= 1'b0;
        @(posedge clk);
        chk("cont", 1, cont);
        chk("standby", 0, stby);
        chk("ready", 1, rdy_n);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        conv(rnd());
        chk("ready", 0, rdy_n);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
